/* File: verilog/fail_safe_clock_monitor.sv */
// Fail-safe clock monitor with start-up clock switching and watchdog.
// Assumes an AHB-Lite master on hclk; oscillator pins are asynchronous.
//
// What this block does
// R1: Monitor runs only when enabled; RC oscillator kept running
// R2: Sample clock is RC oscillator divided by 64
// R3: Latch set by clock fall, cleared by sample rise
// R4: Latch still set at sample fall means failure
// R5: Failure sets fail flag, bit 7 of flags
// R6: Failure switches to internal clock, control register untouched
// R7: Failure clears watchdog counter and postscaler
// R8: Only primary and secondary clocks are watched
// R9: Watchdog has its own divider and counter
// R10: Fail-safe ends only on reset or mode entry
// R11: After reset run internal until primary ready
// R12: Primary never ready: stay internal, register untouched
// R13: Mode entry selects register's source, monitoring resumes
// R14: Failure in managed mode never switches back
// R15: Idle interrupt after failure resumes on internal clock
// R16: External or RC primary: monitor immediately
// R17: Crystal mode: internal clock, no detection until timer
// R18: Primary never starting raises no fail flag
// R19: Select writes and sleep honoured during start-up
// R20: Running bit 3 shows primary clocks the device
// R21: New mode during start-up disables the primary unless that mode selects the primary
// R22: Dual-speed only when configured; auto switch after timer
// R23: Fail flag sticky until software clears it
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/100ps
module fail_safe_clock_monitor #(
   parameter int SAMPLE_DIV = fail_safe_monitor_pkg::SAMPLE_DIV,
   parameter int OST_COUNT = fail_safe_monitor_pkg::OST_CYCLES,
   parameter int WDT_DIV = fail_safe_monitor_pkg::WDT_BASE_DIV
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic primary_clk_in,
   input wire logic secondary_clk_in,
   input wire logic rc_osc_in,
   input wire logic wake_in,
   input wire logic irq_in,
   output logic [1:0] clk_src,
   output logic primary_osc_en,
   output logic rc_osc_en,
   output logic cpu_run,
   output logic monitor_active,
   output logic osc_fail_irq,
   output logic wdt_reset
);
   // Pin synchronisers
   fail_safe_monitor_pkg::pins_t pins_meta_r;
   fail_safe_monitor_pkg::pins_t pins_sync_r;
   fail_safe_monitor_pkg::pins_t pins_prev_r;
   fail_safe_monitor_pkg::pins_t pin_rise;
   fail_safe_monitor_pkg::pins_t pin_fall;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pins_meta_r <= '0;
         pins_sync_r <= '0;
         pins_prev_r <= '0;
      end else begin
         pins_meta_r <= {irq_in, wake_in, rc_osc_in, secondary_clk_in, primary_clk_in};
         pins_sync_r <= pins_meta_r;
         pins_prev_r <= pins_sync_r;
      end
   end

   assign pin_rise = pins_sync_r & ~pins_prev_r;
   assign pin_fall = ~pins_sync_r & pins_prev_r;

   // Registers
   fail_safe_monitor_pkg::cfg_t cfg_r;
   logic [1:0] sel_r;
   logic fail_flag_r;
   logic wdt_en_r;
   logic [15:0] wdt_lim_r;
   fail_safe_monitor_pkg::fsm_state_t state_r;
   fail_safe_monitor_pkg::fsm_state_t state_nxt;
   fail_safe_monitor_pkg::clk_src_t src_r;
   fail_safe_monitor_pkg::clk_src_t src_nxt;
   fail_safe_monitor_pkg::clk_src_t sel_src;
   logic idle_r;
   logic primary_en_r;
   logic [15:0] wdt_ps_r;
   logic wdt_reset_r;

   // AHB-Lite slave, zero wait states
   logic addr_ok;
   logic take;
   logic wr_pend_r;
   logic [7:0] addr_r;
   logic [31:0] rd_mux;
   logic [31:0] hrdata_r;
   logic wr_osc;
   logic wr_irq;
   logic wr_cfg;
   logic wr_pm;
   logic wr_wdt;

   assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
   assign take = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
      end else if (hready) begin
         wr_pend_r <= take && hwrite && addr_ok;
         addr_r <= haddr[7:0];
      end
   end

   assign wr_osc = wr_pend_r && (addr_r == fail_safe_monitor_pkg::OSC_CTRL_OFF);
   assign wr_irq = wr_pend_r && (addr_r == fail_safe_monitor_pkg::IRQ_FLAGS_OFF);
   assign wr_cfg = wr_pend_r && (addr_r == fail_safe_monitor_pkg::CFG_OFF);
   assign wr_pm = wr_pend_r && (addr_r == fail_safe_monitor_pkg::PM_CTRL_OFF);
   assign wr_wdt = wr_pend_r && (addr_r == fail_safe_monitor_pkg::WDT_CTRL_OFF);

   always_comb begin
      rd_mux = 32'h00000000;
      case (haddr[7:0])
         fail_safe_monitor_pkg::OSC_CTRL_OFF: begin
            rd_mux[fail_safe_monitor_pkg::SEL_LSB +: 2] = sel_r;
            rd_mux[fail_safe_monitor_pkg::RUNNING_BIT] = (src_r == fail_safe_monitor_pkg::SRC_PRIMARY)
                                            && (state_r != fail_safe_monitor_pkg::ST_START); // R20
         end
         fail_safe_monitor_pkg::IRQ_FLAGS_OFF: begin
            rd_mux[fail_safe_monitor_pkg::FAIL_BIT] = fail_flag_r;
         end
         fail_safe_monitor_pkg::CFG_OFF: begin
            rd_mux[fail_safe_monitor_pkg::CFG_LSB +: 4] = cfg_r;
         end
         fail_safe_monitor_pkg::STATUS_OFF: begin
            rd_mux[1:0] = state_r;
            rd_mux[3:2] = src_r;
            rd_mux[4] = idle_r;
            rd_mux[5] = monitor_active;
            rd_mux[31:16] = wdt_ps_r;
         end
         fail_safe_monitor_pkg::WDT_CTRL_OFF: begin
            rd_mux[fail_safe_monitor_pkg::WDT_EN_BIT] = wdt_en_r;
            rd_mux[fail_safe_monitor_pkg::WDT_LIM_LSB +: 16] = wdt_lim_r;
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   // Read data sampled in the address phase, so a read right after a
   // write to the same register returns the value before that write.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h00000000;
      end else if (take && !hwrite) begin
         hrdata_r <= addr_ok ? rd_mux : 32'h00000000;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Software-owned registers; hardware never rewrites sel_r
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_r <= fail_safe_monitor_pkg::SEL_RST;
      end else if (wr_osc) begin
         sel_r <= hwdata[fail_safe_monitor_pkg::SEL_LSB +: 2]; // R6 R12 R19
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r <= fail_safe_monitor_pkg::CFG_RST;
      end else if (wr_cfg) begin
         cfg_r <= fail_safe_monitor_pkg::cfg_t'(hwdata[fail_safe_monitor_pkg::CFG_LSB +: 4]);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdt_en_r <= 1'b0;
         wdt_lim_r <= fail_safe_monitor_pkg::WDT_LIM_RST;
      end else if (wr_wdt) begin
         wdt_en_r <= hwdata[fail_safe_monitor_pkg::WDT_EN_BIT];
         wdt_lim_r <= hwdata[fail_safe_monitor_pkg::WDT_LIM_LSB +: 16];
      end
   end

   // Power-managed mode requests
   logic sleep_req;
   logic idle_req;
   logic switch_req;
   assign sleep_req = wr_pm && hwdata[fail_safe_monitor_pkg::PM_SLEEP_BIT];
   assign idle_req = wr_pm && hwdata[fail_safe_monitor_pkg::PM_IDLE_BIT];
   assign switch_req = wr_pm && (hwdata[fail_safe_monitor_pkg::PM_SWITCH_BIT] || hwdata[fail_safe_monitor_pkg::PM_IDLE_BIT]);

   // Sample clock and oscillator start-up timer
   logic sample_rise;
   logic sample_fall;
   logic ost_done;

   rc_tick_divider #(.DIV(SAMPLE_DIV)) sample_div ( // R2
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(1'b0),
      .tick(pin_rise.rc),
      .rise(sample_rise),
      .fall(sample_fall)
   );

   startup_timer #(.COUNT(OST_COUNT)) osc_startup_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(state_r != fail_safe_monitor_pkg::ST_START),
      .edge_in(pin_rise.primary),
      .done(ost_done)
   );

   // Clock-seen latch and failure detection
   logic seen_latch_r;
   logic mon_fall;
   logic fail_evt;

   assign mon_fall = (src_r == fail_safe_monitor_pkg::SRC_PRIMARY) ? pin_fall.primary : pin_fall.secondary;
   assign monitor_active = cfg_r.monitor_enable_cfg && (state_r == fail_safe_monitor_pkg::ST_RUN)
                           && (src_r != fail_safe_monitor_pkg::SRC_INTERNAL); // R1 R8 R17 R18

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen_latch_r <= 1'b0;
      end else if (mon_fall) begin
         seen_latch_r <= 1'b1; // R3
      end else if (sample_rise) begin
         seen_latch_r <= 1'b0; // R3
      end
   end

   assign fail_evt = monitor_active && sample_fall && seen_latch_r; // R4

   // Sticky flag; a new failure wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fail_flag_r <= 1'b0;
      end else if (fail_evt) begin
         fail_flag_r <= 1'b1; // R5 R23
      end else if (wr_irq && hwdata[fail_safe_monitor_pkg::FAIL_BIT]) begin
         fail_flag_r <= 1'b0; // R23
      end
   end

   assign osc_fail_irq = fail_flag_r;

   // Clock source state machine
   logic primary_ready;
   assign sel_src = sel_r[1] ? fail_safe_monitor_pkg::SRC_INTERNAL : fail_safe_monitor_pkg::clk_src_t'(sel_r);
   assign primary_ready = (cfg_r.mode != fail_safe_monitor_pkg::MODE_HS) || ost_done; // R16 R17

   always_comb begin
      state_nxt = state_r;
      src_nxt = src_r;
      case (state_r)
         fail_safe_monitor_pkg::ST_START: begin
            src_nxt = fail_safe_monitor_pkg::SRC_INTERNAL; // R11 R12 R17
            if (sleep_req) begin
               state_nxt = fail_safe_monitor_pkg::ST_SLEEP; // R19
            end else if (switch_req) begin
               state_nxt = fail_safe_monitor_pkg::ST_RUN; // R19 R21
               src_nxt = sel_src;
            end else if (primary_ready) begin
               state_nxt = fail_safe_monitor_pkg::ST_RUN; // R11 R22
               src_nxt = fail_safe_monitor_pkg::SRC_PRIMARY;
            end
         end
         fail_safe_monitor_pkg::ST_RUN: begin
            if (fail_evt) begin
               state_nxt = fail_safe_monitor_pkg::ST_FAILSAFE; // R6
               src_nxt = fail_safe_monitor_pkg::SRC_INTERNAL;
            end else if (sleep_req) begin
               state_nxt = fail_safe_monitor_pkg::ST_SLEEP;
            end else if (switch_req) begin
               src_nxt = sel_src; // R13
            end
         end
         fail_safe_monitor_pkg::ST_FAILSAFE: begin
            // No way back to the failed source without a new mode entry
            if (sleep_req) begin
               state_nxt = fail_safe_monitor_pkg::ST_SLEEP; // R10
            end else if (switch_req) begin
               state_nxt = fail_safe_monitor_pkg::ST_RUN; // R10 R13
               src_nxt = sel_src;
            end else begin
               src_nxt = fail_safe_monitor_pkg::SRC_INTERNAL; // R14
            end
         end
         fail_safe_monitor_pkg::ST_SLEEP: begin
            src_nxt = fail_safe_monitor_pkg::SRC_INTERNAL;
            if (pin_rise.wake) begin
               state_nxt = fail_safe_monitor_pkg::ST_START; // R16 R17
            end
         end
         default: begin
            state_nxt = fail_safe_monitor_pkg::ST_START;
            src_nxt = fail_safe_monitor_pkg::SRC_INTERNAL;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= fail_safe_monitor_pkg::ST_START;
         src_r <= fail_safe_monitor_pkg::SRC_INTERNAL;
      end else begin
         state_r <= state_nxt;
         src_r <= src_nxt;
      end
   end

   // Primary oscillator runs during start-up and while it is selected
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         primary_en_r <= 1'b1;
      end else begin
         case (state_nxt)
            fail_safe_monitor_pkg::ST_START: primary_en_r <= 1'b1;
            fail_safe_monitor_pkg::ST_SLEEP: primary_en_r <= 1'b0;
            default: primary_en_r <= (src_nxt == fail_safe_monitor_pkg::SRC_PRIMARY); // R21
         endcase
      end
   end

   assign primary_osc_en = primary_en_r;
   assign clk_src = src_r;
   assign rc_osc_en = cfg_r.monitor_enable_cfg || wdt_en_r
                      || (src_r == fail_safe_monitor_pkg::SRC_INTERNAL); // R1 R9

   // Idle: CPU halted, clock kept; an interrupt resumes on current source
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_r <= 1'b0;
      end else if (idle_req) begin
         idle_r <= 1'b1;
      end else if (pin_rise.irq || state_r == fail_safe_monitor_pkg::ST_SLEEP) begin
         idle_r <= 1'b0; // R15
      end
   end

   // Without dual-speed start the CPU waits for the crystal
   assign cpu_run = !idle_r && (state_r != fail_safe_monitor_pkg::ST_SLEEP)
                    && !((state_r == fail_safe_monitor_pkg::ST_START) && (cfg_r.mode == fail_safe_monitor_pkg::MODE_HS)
                         && !cfg_r.dual_speed_start_cfg); // R22

   // Watchdog on its own divider, so the sample clock is undisturbed
   logic wdt_clr;
   logic wdt_tick;
   assign wdt_clr = fail_evt || sleep_req || !wdt_en_r
                    || (wr_wdt && hwdata[fail_safe_monitor_pkg::WDT_CLR_BIT]); // R7

   rc_tick_divider #(.DIV(WDT_DIV)) wdt_div ( // R9
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(wdt_clr),
      .tick(pin_rise.rc),
      .rise(wdt_tick),
      .fall()
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdt_ps_r <= 16'h0000;
         wdt_reset_r <= 1'b0;
      end else if (wdt_clr) begin
         wdt_ps_r <= 16'h0000; // R7
         wdt_reset_r <= 1'b0;
      end else if (wdt_tick) begin
         wdt_reset_r <= (wdt_ps_r == wdt_lim_r);
         wdt_ps_r <= (wdt_ps_r == wdt_lim_r) ? 16'h0000 : wdt_ps_r + 16'h0001;
      end else begin
         wdt_reset_r <= 1'b0;
      end
   end

   assign wdt_reset = wdt_reset_r;
endmodule

/* File: verilog/fail_safe_monitor_pkg.sv */
// Constants, offsets, field layouts and types of the clock monitor block.
// Assumes a 32-bit AHB-Lite register port and a single 100 MHz hclk.
package fail_safe_monitor_pkg;
   // Register byte offsets
   localparam logic [7:0] OSC_CTRL_OFF = 8'h00;
   localparam logic [7:0] IRQ_FLAGS_OFF = 8'h04;
   localparam logic [7:0] CFG_OFF = 8'h08;
   localparam logic [7:0] PM_CTRL_OFF = 8'h0c;
   localparam logic [7:0] STATUS_OFF = 8'h10;
   localparam logic [7:0] WDT_CTRL_OFF = 8'h14;
   // Field positions
   localparam int SEL_LSB = 0;
   localparam int RUNNING_BIT = 3;
   localparam int FAIL_BIT = 7;
   localparam int CFG_LSB = 0;
   localparam int PM_SLEEP_BIT = 0;
   localparam int PM_IDLE_BIT = 1;
   localparam int PM_SWITCH_BIT = 2;
   localparam int WDT_EN_BIT = 0;
   localparam int WDT_CLR_BIT = 1;
   localparam int WDT_LIM_LSB = 16;
   // Timing counts and pin count
   localparam int SAMPLE_DIV = 64;
   localparam int OST_CYCLES = 1024;
   localparam int WDT_BASE_DIV = 128;
   localparam int NPINS = 5;

   typedef enum logic [1:0] {
      MODE_HS = 2'b00,
      MODE_EC = 2'b01,
      MODE_RC = 2'b10
   } osc_mode_t;

   typedef enum logic [1:0] {
      SRC_PRIMARY = 2'b00,
      SRC_SECONDARY = 2'b01,
      SRC_INTERNAL = 2'b10
   } clk_src_t;

   typedef enum logic [1:0] {
      ST_START = 2'b00,
      ST_RUN = 2'b01,
      ST_FAILSAFE = 2'b10,
      ST_SLEEP = 2'b11
   } fsm_state_t;

   typedef struct packed {
      osc_mode_t mode;
      logic dual_speed_start_cfg;
      logic monitor_enable_cfg;
   } cfg_t;

   typedef struct packed {
      logic irq;
      logic wake;
      logic rc;
      logic secondary;
      logic primary;
   } pins_t;

   // Reset values
   localparam cfg_t CFG_RST = '{mode: MODE_HS, dual_speed_start_cfg: 1'b1,
                                monitor_enable_cfg: 1'b1};
   localparam logic [1:0] SEL_RST = 2'b00;
   localparam logic [15:0] WDT_LIM_RST = 16'h0080;
endpackage

/* File: verilog/rc_tick_divider.sv */
// Divides a tick stream by DIV and marks the rising and falling edges
// of the divided clock as one-cycle strobes. Assumes ticks are hclk pulses.
`timescale 1ns/100ps
module rc_tick_divider #(
   parameter int DIV = fail_safe_monitor_pkg::SAMPLE_DIV
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clr,
   input wire logic tick,
   output logic rise,
   output logic fall
);
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] cnt_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
      end else if (clr) begin
         cnt_r <= '0;
      end else if (tick) begin
         cnt_r <= (cnt_r == CW'(DIV - 1)) ? '0 : cnt_r + 1'b1;
      end
   end

   // Half period high, half low
   assign rise = tick && !clr && (cnt_r == '0);
   assign fall = tick && !clr && (cnt_r == CW'(DIV / 2));
endmodule

/* File: verilog/startup_timer.sv */
// Counts primary oscillator edges until the oscillator is deemed stable.
// Assumes edge_in is a one-cycle strobe synchronised to hclk.
`timescale 1ns/100ps
module startup_timer #(
   parameter int COUNT = fail_safe_monitor_pkg::OST_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clr,
   input wire logic edge_in,
   output logic done
);
   localparam int CW = $clog2(COUNT + 1);
   logic [CW-1:0] cnt_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
      end else if (clr) begin
         cnt_r <= '0;
      end else if (edge_in && !done) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign done = (cnt_r == CW'(COUNT));
endmodule

/* File: testbench/osc_source_model.sv */
// Pin model: free RC oscillator, crystal and secondary clock.
// Assumes 1 ns units; the crystal runs only while enabled.
`timescale 1ns/100ps
module osc_source_model (
   input wire logic primary_osc_en,
   input wire logic primary_dead,
   output logic primary_clk_in,
   output logic secondary_clk_in,
   output logic rc_osc_in
);
   initial begin
      rc_osc_in = 1'b0;
      primary_clk_in = 1'b0;
      secondary_clk_in = 1'b0;
   end
   // Reference never stops
   always #20 rc_osc_in = ~rc_osc_in;
   // Stands low while disabled or broken
   always #40 primary_clk_in = primary_osc_en && !primary_dead && !primary_clk_in;
   // Slow source
   always #60 secondary_clk_in = ~secondary_clk_in;
endmodule

/* File: testbench/fail_safe_monitor_chk.sv */
// Assertions on the clock monitor top ports.
// Assumes one hclk domain, hresetn active low.
`timescale 1ns/100ps
module fail_safe_monitor_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [1:0] clk_src,
   input wire logic rc_osc_en,
   input wire logic monitor_active,
   input wire logic osc_fail_irq,
   input wire logic wdt_reset
);
   logic wr_take;
   logic flag_wr_r;
   logic pm_wr_r;
   logic fail_d_r;
   logic fs_r;
   assign wr_take = hsel && hready && htrans[1] && hwrite;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_wr_r <= 1'b0;
         pm_wr_r <= 1'b0;
         fail_d_r <= 1'b0;
         fs_r <= 1'b0;
      end else begin
         flag_wr_r <= wr_take && haddr == {24'h0, fail_safe_monitor_pkg::IRQ_FLAGS_OFF};
         pm_wr_r <= wr_take && haddr == {24'h0, fail_safe_monitor_pkg::PM_CTRL_OFF};
         fail_d_r <= osc_fail_irq;
         fs_r <= (osc_fail_irq && !fail_d_r) || (fs_r && !pm_wr_r);
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_fail;
      $rose(osc_fail_irq);
   endsequence
   sequence s_wdt_quiet;
      !wdt_reset [*8];
   endsequence
   a_fail_internal: assert property (s_fail |-> clk_src == 2'b10)
      else $error("failure left the external clock selected");
   a_fail_armed: assert property (s_fail |-> $past(monitor_active))
      else $error("failure flagged while monitor idle");
   a_fail_from_ext: assert property (s_fail |-> $past(clk_src) != 2'b10)
      else $error("failure flagged on internal clock");
   a_fail_wdt_clear: assert property (s_fail |-> s_wdt_quiet)
      else $error("watchdog fired right after failure");
   a_flag_sticky: assert property ($fell(osc_fail_irq) |-> $past(flag_wr_r && hwdata[7]))
      else $error("fail flag dropped without software clear");
   a_watch_external: assert property (monitor_active |-> clk_src != 2'b10)
      else $error("monitor armed on internal clock");
   a_rc_running: assert property (monitor_active |-> rc_osc_en)
      else $error("reference oscillator off while monitoring");
   a_failsafe_held: assert property (fs_r && !pm_wr_r |=> clk_src == 2'b10)
      else $error("left fail-safe without mode entry");
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the clock monitor over AHB-Lite.
// Assumes the pin model drives all oscillator inputs.
`timescale 1ns/100ps
module testbench;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, wake_in, irq_in;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, clk_src;
   logic pri_clk, sec_clk, rc_clk, primary_dead, primary_osc_en, rc_osc_en;
   logic cpu_run, monitor_active, osc_fail_irq, wdt_reset;
   int n_fail = 0;
   int check_count = 0;

   // Short counts keep the run brief
   fail_safe_clock_monitor #(.OST_COUNT(8), .WDT_DIV(4)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .primary_clk_in(pri_clk), .secondary_clk_in(sec_clk), .rc_osc_in(rc_clk),
      .wake_in(wake_in), .irq_in(irq_in), .clk_src(clk_src),
      .primary_osc_en(primary_osc_en), .rc_osc_en(rc_osc_en), .cpu_run(cpu_run),
      .monitor_active(monitor_active), .osc_fail_irq(osc_fail_irq), .wdt_reset(wdt_reset));
   osc_source_model osc_u (.primary_osc_en(primary_osc_en), .primary_dead(primary_dead),
      .primary_clk_in(pri_clk), .secondary_clk_in(sec_clk), .rc_osc_in(rc_clk));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      @(negedge hclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0, q);
   endtask

   task automatic wait_fail;
      for (int i = 0; i < 600 && osc_fail_irq !== 1'b1; i++) @(negedge hclk);
   endtask

   task automatic pulse(input logic wk);
      @(posedge hclk);
      if (wk) wake_in <= 1'b1;
      else irq_in <= 1'b1;
      repeat (4) @(posedge hclk);
      wake_in <= 1'b0;
      irq_in <= 1'b0;
      repeat (6) @(negedge hclk);
   endtask

   task automatic t_reset_view;
      rd(fail_safe_monitor_pkg::CFG_OFF);
      chk(q[3:0], 32'h3);
      // Watchdog still off here, monitor on: reference must run
      chk({hresp, rc_osc_en}, 32'h1);
      // Monitor off so start-up can be watched without a trip
      wr(fail_safe_monitor_pkg::CFG_OFF, 32'h2);
      rd(fail_safe_monitor_pkg::OSC_CTRL_OFF);
      chk(q[3:0], 32'h0);
      chk(clk_src, 32'h2);
      chk(monitor_active, 32'h0);
      rd(8'h40);
      chk(q, 32'h0);
   endtask

   task automatic t_startup;
      for (int i = 0; i < 500 && clk_src !== 2'b00; i++) @(negedge hclk);
      chk(clk_src, 32'h0);
      rd(fail_safe_monitor_pkg::OSC_CTRL_OFF);
      chk(q[3], 32'h1);
      chk(monitor_active, 32'h0);
      repeat (300) @(negedge hclk);
      chk(osc_fail_irq, 32'h0);
   endtask

   task automatic t_wdt;
      // Small limit; left running so later failures must clear it
      wr(fail_safe_monitor_pkg::WDT_CTRL_OFF, 32'h00030001);
      for (int i = 0; i < 200 && wdt_reset !== 1'b1; i++) @(negedge hclk);
      chk(wdt_reset, 32'h1);
      rd(fail_safe_monitor_pkg::WDT_CTRL_OFF);
      chk(q, 32'h00030001);
   endtask

   task automatic t_detect;
      wr(fail_safe_monitor_pkg::CFG_OFF, 32'h3);
      chk(monitor_active, 32'h1);
      wait_fail();
      chk(osc_fail_irq, 32'h1);
      chk(clk_src, 32'h2);
      rd(fail_safe_monitor_pkg::OSC_CTRL_OFF);
      chk(q[3:0], 32'h0);
      rd(fail_safe_monitor_pkg::IRQ_FLAGS_OFF);
      chk(q, 32'h80);
      repeat (300) @(negedge hclk);
      chk({osc_fail_irq, clk_src}, 32'h6);
      wr(fail_safe_monitor_pkg::IRQ_FLAGS_OFF, 32'h80);
      rd(fail_safe_monitor_pkg::IRQ_FLAGS_OFF);
      chk(q, 32'h0);
      chk(clk_src, 32'h2);
   endtask

   task automatic t_pm_secondary;
      wr(fail_safe_monitor_pkg::OSC_CTRL_OFF, 32'h1);
      wr(fail_safe_monitor_pkg::PM_CTRL_OFF, 32'h4);
      chk(clk_src, 32'h1);
      chk(monitor_active, 32'h1);
      wait_fail();
      chk(osc_fail_irq, 32'h1);
      repeat (100) @(negedge hclk);
      chk(clk_src, 32'h2);
      wr(fail_safe_monitor_pkg::IRQ_FLAGS_OFF, 32'h80);
   endtask

   task automatic t_wake_ec;
      wr(fail_safe_monitor_pkg::CFG_OFF, 32'h6);
      wr(fail_safe_monitor_pkg::OSC_CTRL_OFF, 32'h0);
      wr(fail_safe_monitor_pkg::PM_CTRL_OFF, 32'h1);
      chk(cpu_run, 32'h0);
      pulse(1'b1);
      chk(clk_src, 32'h0);
      chk(cpu_run, 32'h1);
   endtask

   task automatic t_no_start;
      primary_dead <= 1'b1;
      // Sleep first, so the monitor is never armed on the dying crystal
      wr(fail_safe_monitor_pkg::PM_CTRL_OFF, 32'h1);
      wr(fail_safe_monitor_pkg::CFG_OFF, 32'h3);
      pulse(1'b1);
      repeat (1500) @(negedge hclk);
      chk(osc_fail_irq, 32'h0);
      chk({cpu_run, clk_src}, 32'h6);
      rd(fail_safe_monitor_pkg::OSC_CTRL_OFF);
      chk(q[3:0], 32'h0);
      // Internal select plus idle while still waiting on the crystal
      wr(fail_safe_monitor_pkg::OSC_CTRL_OFF, 32'h2);
      wr(fail_safe_monitor_pkg::PM_CTRL_OFF, 32'h2);
      chk(cpu_run, 32'h0);
      chk(primary_osc_en, 32'h0);
      pulse(1'b0);
      chk({cpu_run, clk_src}, 32'h6);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   initial begin
      #200000;
      n_fail++;
      $display("ERROR at %0t: run timed out", $time);
      report_and_stop();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      wake_in = 1'b0;
      irq_in = 1'b0;
      primary_dead = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      t_reset_view();
      t_startup();
      t_wdt();
      t_detect();
      t_pm_secondary();
      t_wake_ec();
      t_no_start();
      report_and_stop();
   end
endmodule

bind fail_safe_clock_monitor fail_safe_monitor_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .clk_src(clk_src), .rc_osc_en(rc_osc_en), .monitor_active(monitor_active),
   .osc_fail_irq(osc_fail_irq), .wdt_reset(wdt_reset));
